// File: rtl/amc_mode_control.sv
// converter mode control register with restart and settling delay logic
`timescale 1ns/1ps
// Summary of operation
// - any write to the mode control register restarts the filter, clears ready and starts anew.
// - the register sits at address 0x01 and resets to 0x2000.
// - bit 15 turns on the internal reference and its buffered output, reset 0.
// - bit 13 resets to 1 and asks for settled-only output with one channel active.
// - bits 10:8 choose a settling delay from 0 us to 8 ms after each channel switch.
// - bits 6:4 choose the operating mode, conversion, standby, power-down or calibration.
// - bits 3:2 choose the master clock source and how the clock pins are used.
// - either internal oscillator choice also powers up the oscillator.
module amc_mode_control (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// converter core
	input  wire logic        channel_switch,
	input  wire logic        conv_ready,
	output logic             filter_restart,
	output logic             conv_start,
	output logic             ready_flag,
	output logic             input_enable,
	output logic      [2:0]  op_mode,
	output logic             settled_only_output,
	// reference and clock
	output logic             ref_enable,
	output logic      [1:0]  clock_source_select,
	output logic             osc_enable,
	output logic             clk_out_enable,
	output logic             ext_clk_select,
	output logic             xtal_enable
);
	import amc_pkg::*;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [15:0]          mode_reg, mode_next;
	logic [15:0]          rdata_reg, rdata_next;
	logic                 restart_reg, restart_next;
	logic                 start_reg, start_next;
	logic                 ready_reg, ready_next;
	logic                 inen_reg, inen_next;
	logic [2:0]           opm_reg, opm_next;
	logic                 sing_reg, sing_next;
	logic                 refen_reg, refen_next;
	logic [1:0]           clks_reg, clks_next;
	logic                 osc_reg, osc_next;
	logic                 ckout_reg, ckout_next;
	logic                 ext_reg, ext_next;
	logic                 xtal_reg, xtal_next;
	logic                 mode_wr;
	logic [AMC_DLY_W-1:0] dly_cycles;
	logic                 tmr_busy;
	logic                 tmr_done;
	logic [2:0]           dly_code;
	amc_clksel_t          cs;

	assign mode_wr = reg_wr && (reg_addr == AMC_ADDR_MODE);
	assign dly_code = mode_reg[AMC_DELAY_LSB +: 3];

	// ------------------------------------------------------------
	// settling delay lookup
	// ------------------------------------------------------------
	always_comb begin
		unique case (dly_code)
			3'h0: dly_cycles = '0;
			3'h1: dly_cycles = AMC_DLY_W'(AMC_DLY1_CYC);
			3'h2: dly_cycles = AMC_DLY_W'(AMC_DLY2_CYC);
			3'h3: dly_cycles = AMC_DLY_W'(AMC_DLY3_CYC);
			3'h4: dly_cycles = AMC_DLY_W'(AMC_DLY4_CYC);
			3'h5: dly_cycles = AMC_DLY_W'(AMC_DLY5_CYC);
			3'h6: dly_cycles = AMC_DLY_W'(AMC_DLY6_CYC);
			3'h7: dly_cycles = AMC_DLY_W'(AMC_DLY7_CYC);
		endcase
	end

	// ------------------------------------------------------------
	// settling timer
	// ------------------------------------------------------------
	// timer restarts on a channel switch; a register write aborts it
	amc_settle_timer u_settle (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.start      (channel_switch),
		.abort      (mode_wr),
		.load_count (dly_cycles),
		.busy       (tmr_busy),
		.done       (tmr_done)
	);

	// ------------------------------------------------------------
	// stored word and read data
	// ------------------------------------------------------------
	// reserved read-only bits are masked on the way in, so reads
	// need no mask and a stray write never shows up later
	always_comb begin
		mode_next  = mode_reg;
		rdata_next = 16'h0000;
		if (mode_wr) begin
			// read-only reserved bits keep zero; bit 14 stores
			mode_next = reg_wdata & AMC_WRITABLE_MASK;
		end
		if (reg_rd && (reg_addr == AMC_ADDR_MODE)) begin
			rdata_next = mode_reg;
		end
	end

	// stored word and read data registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_reg  <= AMC_MODE_RESET;
			rdata_reg <= 16'h0000;
		end else begin
			mode_reg  <= mode_next;
			rdata_reg <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// restart handshake with the converter core
	// ------------------------------------------------------------
	// a write clears ready even when a result lands in the same cycle:
	// the write restarts the filter, so that result is already stale
	always_comb begin
		restart_next = mode_wr;
		start_next   = mode_wr || (tmr_done && !mode_wr);
		ready_next   = ready_reg;
		if (conv_ready) begin
			ready_next = 1'b1;
		end
		if (mode_wr) begin
			ready_next = 1'b0;
		end
		// input held off from the switch edge until the timer ends
		inen_next = !(tmr_busy || (channel_switch && dly_cycles != '0));
	end

	// handshake registers; input enabled out of reset, nothing pending
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			restart_reg <= 1'b0;
			start_reg   <= 1'b0;
			ready_reg   <= 1'b0;
			inen_reg    <= 1'b1;
		end else begin
			restart_reg <= restart_next;
			start_reg   <= start_next;
			ready_reg   <= ready_next;
			inen_reg    <= inen_next;
		end
	end

	// ------------------------------------------------------------
	// field decode for core, reference and clock pins
	// ------------------------------------------------------------
	// clock choice held in the reset word, so the decoded enables come
	// out of reset consistent with the stored value
	localparam amc_clksel_t AMC_RESET_CLKSEL =
		amc_clksel_t'(AMC_MODE_RESET[AMC_CLKSEL_LSB +: 2]);

	// decoded from the next word so the fields move on the storing edge;
	// costs a little depth on the write path, saves a cycle of skew
	always_comb begin
		cs         = amc_clksel_t'(mode_next[AMC_CLKSEL_LSB +: 2]);
		opm_next   = mode_next[AMC_MODE_LSB +: 3];
		sing_next  = mode_next[AMC_BIT_SETTLED];
		refen_next = mode_next[AMC_BIT_REF_EN];
		clks_next  = mode_next[AMC_CLKSEL_LSB +: 2];
		osc_next   = (cs == AMC_CLK_INT) || (cs == AMC_CLK_INT_OUT);
		ckout_next = (cs == AMC_CLK_INT_OUT);
		ext_next   = (cs == AMC_CLK_EXT);
		xtal_next  = (cs == AMC_CLK_XTAL);
	end

	// field registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			opm_reg   <= AMC_MODE_RESET[AMC_MODE_LSB +: 3];
			sing_reg  <= AMC_MODE_RESET[AMC_BIT_SETTLED];
			refen_reg <= AMC_MODE_RESET[AMC_BIT_REF_EN];
			clks_reg  <= AMC_MODE_RESET[AMC_CLKSEL_LSB +: 2];
			osc_reg   <= (AMC_RESET_CLKSEL == AMC_CLK_INT) ||
				(AMC_RESET_CLKSEL == AMC_CLK_INT_OUT);
			ckout_reg <= (AMC_RESET_CLKSEL == AMC_CLK_INT_OUT);
			ext_reg   <= (AMC_RESET_CLKSEL == AMC_CLK_EXT);
			xtal_reg  <= (AMC_RESET_CLKSEL == AMC_CLK_XTAL);
		end else begin
			opm_reg   <= opm_next;
			sing_reg  <= sing_next;
			refen_reg <= refen_next;
			clks_reg  <= clks_next;
			osc_reg   <= osc_next;
			ckout_reg <= ckout_next;
			ext_reg   <= ext_next;
			xtal_reg  <= xtal_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// outputs straight from flip-flops
	assign reg_rdata           = rdata_reg;
	assign filter_restart      = restart_reg;
	assign conv_start          = start_reg;
	assign ready_flag          = ready_reg;
	assign input_enable        = inen_reg;
	assign op_mode             = opm_reg;
	assign settled_only_output = sing_reg;
	assign ref_enable          = refen_reg;
	assign clock_source_select = clks_reg;
	assign osc_enable          = osc_reg;
	assign clk_out_enable      = ckout_reg;
	assign ext_clk_select      = ext_reg;
	assign xtal_enable         = xtal_reg;

endmodule

// File: rtl/amc_pkg.sv
// package: register map, field layout and timing constants for the mode control block
package amc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0]  AMC_ADDR_MODE       = 8'h01;
	localparam logic [15:0] AMC_MODE_RESET      = 16'h2000;
	// bits that store a written value (15, 14, 13, 10:8, 6:4, 3:2)
	localparam logic [15:0] AMC_WRITABLE_MASK   = 16'he77c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int AMC_BIT_REF_EN     = 15;
	localparam int AMC_BIT_SETTLED    = 13;
	localparam int AMC_DELAY_LSB      = 8;
	localparam int AMC_MODE_LSB       = 4;
	localparam int AMC_CLKSEL_LSB     = 2;

	// operating modes
	typedef enum logic [2:0] {
		AMC_MODE_CONT     = 3'h0,
		AMC_MODE_SINGLE   = 3'h1,
		AMC_MODE_STANDBY  = 3'h2,
		AMC_MODE_PWRDN    = 3'h3,
		AMC_MODE_CAL_IOFS = 3'h4,
		AMC_MODE_CAL_IGN  = 3'h5,
		AMC_MODE_CAL_SOFS = 3'h6,
		AMC_MODE_CAL_SGN  = 3'h7
	} amc_mode_t;

	// clock sources
	typedef enum logic [1:0] {
		AMC_CLK_INT      = 2'h0,
		AMC_CLK_INT_OUT  = 2'h1,
		AMC_CLK_EXT      = 2'h2,
		AMC_CLK_XTAL     = 2'h3
	} amc_clksel_t;

	// ------------------------------------------------------------
	// settling delay table, in ns, and in 25 ns clock cycles
	// ------------------------------------------------------------
	localparam int AMC_CLK_PERIOD_NS = 25;
	localparam int AMC_DLY1_NS = 32000;
	localparam int AMC_DLY2_NS = 128000;
	localparam int AMC_DLY3_NS = 320000;
	localparam int AMC_DLY4_NS = 800000;
	localparam int AMC_DLY5_NS = 1600000;
	localparam int AMC_DLY6_NS = 4000000;
	localparam int AMC_DLY7_NS = 8000000;
	localparam int AMC_DLY_W   = 19;
	localparam int AMC_DLY1_CYC = AMC_DLY1_NS / AMC_CLK_PERIOD_NS;
	localparam int AMC_DLY2_CYC = AMC_DLY2_NS / AMC_CLK_PERIOD_NS;
	localparam int AMC_DLY3_CYC = AMC_DLY3_NS / AMC_CLK_PERIOD_NS;
	localparam int AMC_DLY4_CYC = AMC_DLY4_NS / AMC_CLK_PERIOD_NS;
	localparam int AMC_DLY5_CYC = AMC_DLY5_NS / AMC_CLK_PERIOD_NS;
	localparam int AMC_DLY6_CYC = AMC_DLY6_NS / AMC_CLK_PERIOD_NS;
	localparam int AMC_DLY7_CYC = AMC_DLY7_NS / AMC_CLK_PERIOD_NS;

	// settle timer states, gray along idle -> wait -> done
	typedef enum logic [1:0] {
		AMC_ST_IDLE = 2'b00,
		AMC_ST_WAIT = 2'b01,
		AMC_ST_DONE = 2'b11
	} amc_state_t;

endpackage

// File: rtl/amc_settle_timer.sv
// settling delay timer started by a channel switch
`timescale 1ns/1ps
module amc_settle_timer (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// control
	input  wire logic                      start,
	input  wire logic                      abort,
	input  wire logic [amc_pkg::AMC_DLY_W-1:0] load_count,
	// status
	output logic                           busy,
	output logic                           done
);
	import amc_pkg::*;

	amc_state_t             state_reg, state_next;
	logic [AMC_DLY_W-1:0]   cnt_reg, cnt_next;
	logic                   done_reg, done_next;

	// next state: a restart mid-wait reloads, so the latest switch wins
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		done_next  = 1'b0;
		unique case (state_reg)
			AMC_ST_IDLE, AMC_ST_DONE: begin
				state_next = AMC_ST_IDLE;
			end
			AMC_ST_WAIT: begin
				if (cnt_reg <= AMC_DLY_W'(1)) begin
					state_next = AMC_ST_DONE;
					done_next  = 1'b1;
				end else begin
					cnt_next = cnt_reg - AMC_DLY_W'(1);
				end
			end
			default: state_next = AMC_ST_IDLE;
		endcase
		if (start) begin
			if (load_count == '0) begin
				state_next = AMC_ST_DONE;
				done_next  = 1'b1;      // zero delay: done in one cycle
			end else begin
				state_next = AMC_ST_WAIT;
				cnt_next   = load_count;
				done_next  = 1'b0;
			end
		end
		if (abort) begin
			state_next = AMC_ST_IDLE;
			done_next  = 1'b0;
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= AMC_ST_IDLE;
			cnt_reg   <= '0;
			done_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			done_reg  <= done_next;
		end
	end

	assign busy = (state_reg == AMC_ST_WAIT);
	assign done = done_reg;

endmodule

// File: sim/amc_core_model.sv
// converter core model: answers each start with a ready pulse unless a newer start arrives first
`timescale 1ns/1ps
module amc_core_model #(
	parameter int LAT = 20
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// control from the block
	input  wire logic conv_start,
	// result to the block
	output logic      conv_ready
);
	int cnt_reg;
	// a new start drops any pending result, as a real restart would
	always_ff @(posedge clk) begin
		conv_ready <= 1'b0;
		if (sys_rst) begin
			cnt_reg <= 0;
		end else if (conv_start) begin
			cnt_reg <= LAT;
		end else if (cnt_reg != 0) begin
			cnt_reg <= cnt_reg - 1;
			conv_ready <= (cnt_reg == 1);
		end
	end
endmodule

// File: sim/amc_checker.sv
// checker: port assertions for the mode control block
`timescale 1ns/1ps
module amc_checker
	import amc_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// core and fields
	input wire logic        conv_ready,
	input wire logic        filter_restart,
	input wire logic        conv_start,
	input wire logic        ready_flag,
	input wire logic [2:0]  op_mode,
	input wire logic        settled_only_output,
	input wire logic        ref_enable,
	input wire logic [1:0]  clock_source_select,
	input wire logic        osc_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// write to the mode register
	wire wr_mode = reg_wr && reg_addr == AMC_ADDR_MODE;
	a_write_restart: assert property (wr_mode |=> filter_restart && conv_start && !ready_flag)
		else $error("write did not restart");
	a_no_restart: assert property (!wr_mode |=> !filter_restart)
		else $error("restart without write");
	a_ready_set: assert property (conv_ready && !wr_mode |=> ready_flag)
		else $error("ready not set");
	a_unmapped_read: assert property (reg_rd && reg_addr != AMC_ADDR_MODE |=> reg_rdata == 16'h0)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (reg_rd |=> (reg_rdata & 16'h1883) == 16'h0)
		else $error("reserved bits not zero");
	a_ref_store: assert property (wr_mode |=> ref_enable == $past(reg_wdata[15]))
		else $error("reference bit wrong");
	a_settled_store: assert property (wr_mode |=> settled_only_output == $past(reg_wdata[13]))
		else $error("settled bit wrong");
	a_mode_store: assert property (wr_mode |=> op_mode == $past(reg_wdata[6:4]))
		else $error("mode field wrong");
	a_clk_store: assert property (wr_mode |=> clock_source_select == $past(reg_wdata[3:2]))
		else $error("clock field wrong");
	a_osc_decode: assert property (osc_enable == !clock_source_select[1])
		else $error("oscillator enable wrong");
	c_write: cover property (wr_mode);
	c_read: cover property (reg_rd);
	c_ready: cover property (conv_ready ##1 ready_flag);
endmodule
bind amc_mode_control amc_checker u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.conv_ready(conv_ready), .filter_restart(filter_restart), .conv_start(conv_start),
	.ready_flag(ready_flag), .op_mode(op_mode), .settled_only_output(settled_only_output),
	.ref_enable(ref_enable), .clock_source_select(clock_source_select),
	.osc_enable(osc_enable));

// File: sim/tb_top.sv
// testbench: register table rows, reset, settle delay and restart cases
`timescale 1ns/1ps
module tb_top;
	import amc_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        channel_switch = 1'b0;
	logic [15:0] reg_rdata, rd_val;
	logic [2:0]  op_mode;
	logic [1:0]  clock_source_select;
	logic        conv_ready, filter_restart, conv_start, ready_flag, input_enable;
	logic        settled_only_output, ref_enable, osc_enable, xtal_enable;
	logic        clk_out_enable, ext_clk_select;
	int          n_errors = 0;
	int          checks_done = 0;
	int          k;
	// written word beside expected readback; rows keep reserved bits zero
	// except the last, which sets them on purpose to show they are dropped
	logic [15:0] rows [8][2] = '{'{16'h2000, 16'h2000}, '{16'h8014, 16'h8014},
		'{16'h0028, 16'h0028}, '{16'ha03c, 16'ha03c}, '{16'h0140, 16'h0140},
		'{16'h4254, 16'h4254}, '{16'h2768, 16'h2768}, '{16'h98ff, 16'h807c}};
	always #12.5 clk = ~clk;
	amc_mode_control DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.channel_switch(channel_switch), .conv_ready(conv_ready),
		.filter_restart(filter_restart), .conv_start(conv_start), .ready_flag(ready_flag),
		.input_enable(input_enable), .op_mode(op_mode),
		.settled_only_output(settled_only_output), .ref_enable(ref_enable),
		.clock_source_select(clock_source_select), .osc_enable(osc_enable),
		.clk_out_enable(clk_out_enable), .ext_clk_select(ext_clk_select),
		.xtal_enable(xtal_enable));
	amc_core_model u_core (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
		.conv_ready(conv_ready));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	// switch pulse, then count edges to the start; bounded wait
	task automatic sw(input int lo, input int hi);
		int n;
		@(posedge clk);
		channel_switch <= 1'b1;
		@(posedge clk);
		channel_switch <= 1'b0;
		n = 1;
		#1 chk(input_enable, lo < 2);
		@(posedge clk);
		#1;
		while (conv_start !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1 n++;
		end
		chk(n >= lo && n <= hi, 1'b1);
		chk(input_enable, 1'b1);
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard, far beyond the longest delay case
	initial begin
		#(25 * 10000);
		n_errors++;
		print_verdict();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(AMC_ADDR_MODE);
		chk(rd_val, 16'h2000);
		chk(settled_only_output, 1'b1);
		chk({ref_enable, osc_enable}, 2'b01);
		$display("test reset done");
		for (k = 0; k < 8; k++) begin
			wr(AMC_ADDR_MODE, rows[k][0]);
			chk({filter_restart, conv_start}, 2'b11);
			chk(ref_enable, rows[k][1][15]);
			chk(settled_only_output, rows[k][1][13]);
			chk(op_mode, rows[k][1][6:4]);
			chk(clock_source_select, rows[k][1][3:2]);
			chk({osc_enable, xtal_enable}, {!rows[k][1][3], rows[k][1][3:2] == 2'h3});
			chk(clk_out_enable, rows[k][1][3:2] == 2'h1);
			chk(ext_clk_select, rows[k][1][3:2] == 2'h2);
			rd(AMC_ADDR_MODE);
			chk(rd_val, rows[k][1]);
		end
		$display("test table done");
		wr(8'h02, 16'hffff);
		chk(filter_restart, 1'b0);
		rd(8'h02);
		chk(rd_val, 16'h0000);
		rd(AMC_ADDR_MODE);
		chk(rd_val, 16'h807c);
		$display("test unmapped done");
		wr(AMC_ADDR_MODE, 16'h2000);
		for (k = 0; k < 100 && ready_flag !== 1'b1; k++)
			@(posedge clk);
		#1 chk(ready_flag, 1'b1);
		wr(AMC_ADDR_MODE, 16'h2000);
		chk(ready_flag, 1'b0);
		$display("test ready done");
		sw(1, 1);
		wr(AMC_ADDR_MODE, 16'h2100);
		sw(AMC_DLY1_CYC, AMC_DLY1_CYC + 4);
		$display("test delay done");
		// a write mid-delay aborts the timer: no late start, input back on
		@(posedge clk);
		channel_switch <= 1'b1;
		@(posedge clk);
		channel_switch <= 1'b0;
		repeat (10) @(posedge clk);
		wr(AMC_ADDR_MODE, 16'h2100);
		chk({conv_start, input_enable}, 2'b10);
		for (k = 0; k < AMC_DLY1_CYC + 8; k++) begin
			@(posedge clk);
			#1 chk({conv_start, input_enable}, 2'b01);
		end
		$display("test abort done");
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(AMC_ADDR_MODE);
		chk(rd_val, 16'h2000);
		$display("test second reset done");
		print_verdict();
	end
endmodule
